// [core/status_reset_pkg.sv]
// Purpose: Shared constants and carriers for the status register and reset chain
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Offsets are byte addresses
package status_reset_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] status_addr_lo = 12'h00_0C; // Data address 03h
  localparam logic [11:0] status_addr_hi = 12'h02_0C; // Data address 83h
  localparam logic [11:0] ctrl_addr = 12'h04_00;
  localparam logic [11:0] seq_addr = 12'h04_04;
  localparam logic [11:0] alu_addr = 12'h04_08;
  localparam logic [11:0] event_addr = 12'h04_0C;

  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int carry_bit = 0;
  localparam int half_byte_overflow_bit = 1;
  localparam int zero_bit = 2;
  localparam int sleep_entered_bit = 3;
  localparam int watchdog_expiry_bit = 4;
  localparam int bank_select_low_bit = 5;
  localparam int bank_select_high_bit = 6;
  localparam int indirect_bank_bit = 7;
  localparam logic [7:0] status_por_value = 8'h18;
  localparam logic [7:0] status_upper_mask = 8'hE0;
  localparam logic [7:0] arith_mask = 8'h07;
  localparam logic [7:0] flag_mask = 8'h18;
  localparam logic [7:0] bank_base_low = 8'h00;
  localparam logic [7:0] bank_base_high = 8'h80;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int power_up_delay_timer_time_ms = 72;
  localparam int rc_osc_hz = 32_000; // Nominal internal RC rate
  localparam int settle_count = 1024;

  // Control register fields
  localparam int ctrl_power_up_delay_timer_en_bit = 0;
  localparam int ctrl_osc_lo_bit = 1; // 2-bit oscillator mode
  // Event register fields (write one to trigger)
  localparam int ev_clear_bit = 0;
  localparam int ev_sleep_bit = 1;
  localparam int ev_wdt_bit = 2;
  localparam int ev_wake_bit = 3;
  localparam int ev_master_clear_pin_bit = 4;
  // ALU register fields
  localparam int alu_a_lo = 0;
  localparam int alu_b_lo = 8;
  localparam int alu_sub_bit = 16;
  localparam int alu_dest_bit = 17;
  localparam int alu_logic_bit = 18;

  typedef enum logic [1:0] {
    crystal_osc_mode,
    low_power_crystal_mode,
    high_speed_crystal_mode,
    resistor_cap_osc_mode
  } osc_mode_e;

  typedef enum logic [1:0] {
    seq_por,
    seq_power_up_delay_timer,
    seq_ost,
    seq_run
  } seq_state_e;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
endpackage

// [core/status_and_reset_timeout.sv]
// Purpose: Processor status register and power-up reset timing chain
// Assumes: Registers reached over APB; supply detector and master clear are pclk-synchronous
// Notes: Power-up delay counts a separate RC oscillator tick; settle counts primary oscillator ticks
// Notes: Writes act only in the run state; reads work at all times
//
// Summary of operation
// - Status writes from flag-updating operations leave zero, digit and carry computed.
// - Status and ALU writes never change watchdog-expiry or sleep-entered flags.
// - Clear of status clears top three bits and sets the zero flag.
// - Bits 7:6 have no effect; software keeps them zero.
// - Subtraction reports carry and digit carry as inverted borrows.
// - Bank select low picks data bank base 00h or 80h.
// - Status decodes at both data addresses 03h and 83h.
// - Supply-rise reset holds chip reset until supply is good.
// - Power-up delay of nominal 72 ms runs only after supply rise.
// - Power-up delay is clocked by a dedicated internal RC tick.
// - Chip stays in reset while the power-up delay counts.
// - Configuration bit enables or bypasses the power-up delay.
// - Settle counter counts 1024 primary oscillator cycles after the delay.
// - Settle runs only in crystal modes, on supply rise or wake.
// - Order is supply reset, then power-up delay, then settle counter.
// - RC mode with delay bypassed gives no time-out at all.
// - Time-outs ignore master clear; its release then starts execution at once.
// - Supply rise sets watchdog-expiry and sleep-entered flags.
// - Master clear in sleep or wake sets expiry, clears sleep-entered flag.
`timescale 1ns/1ps
`default_nettype none
module status_and_reset_timeout #(
  parameter int rc_osc_hz_p = status_reset_pkg::rc_osc_hz,
  parameter int power_up_delay_timer_ticks_p = status_reset_pkg::power_up_delay_timer_time_ms * rc_osc_hz_p / 1000,
  parameter int settle_ticks_p = status_reset_pkg::settle_count
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_good,
  input wire logic rc_osc_tick,
  input wire logic primary_oscillator_input,
  input wire logic master_clear_pin_n,
  output logic chip_reset,
  output logic [7:0] data_bank_base
);
  localparam int power_up_delay_timer_w = $clog2(power_up_delay_timer_ticks_p + 1);
  localparam int settle_w = $clog2(settle_ticks_p + 1);
  // Bits 7:6 are reserved and always held clear
  localparam logic [7:0] reserved_mask =
      (8'h01 << status_reset_pkg::indirect_bank_bit) |
      (8'h01 << status_reset_pkg::bank_select_high_bit);

  typedef struct packed {
    logic [7:0] status;
    logic power_up_delay_timer_en;
    status_reset_pkg::osc_mode_e osc_mode;
    status_reset_pkg::seq_state_e seq;
    logic [power_up_delay_timer_w-1:0] power_up_delay_timer_cnt;
    logic [settle_w-1:0] settle_cnt;
    logic sleeping;
    logic osc_prev;
    logic [31:0] rdata;
    logic [7:0] bank_base;
    logic rst_out;
  } state_s;

  // Whole module state, registered as one word
  state_s st_r;
  state_s st_nxt;

  // Crystal-type oscillator modes need settling
  function automatic logic is_crystal(input status_reset_pkg::osc_mode_e m);
    is_crystal = (m != status_reset_pkg::resistor_cap_osc_mode);
  endfunction

  // Status decode at either bank address
  function automatic logic is_status(input logic [11:0] a);
    is_status = (a == status_reset_pkg::status_addr_lo) || (a == status_reset_pkg::status_addr_hi);
  endfunction

  // Control register decode, shared by writes and reads
  function automatic logic is_ctrl(input logic [11:0] a);
    is_ctrl = (a == status_reset_pkg::ctrl_addr);
  endfunction

  // Bus and arithmetic nets
  logic wr_en;
  logic rd_en;
  logic [8:0] sum_full;
  logic [4:0] sum_half;
  logic [7:0] opnd_b;
  logic [7:0] alu_res;

  // ---------------------------------------------------------------
  // Bus qualifiers and arithmetic unit
  // ---------------------------------------------------------------
  // Access phase only; pready is tied high, so each access ends at its enable edge
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // subtract adds the complement plus one, so carry is inverted borrow
  assign opnd_b = pwdata[status_reset_pkg::alu_sub_bit] ?
      ~pwdata[status_reset_pkg::alu_b_lo +: 8] : pwdata[status_reset_pkg::alu_b_lo +: 8];
  // carries out of bit 3 and bit 7
  assign sum_full = {1'b0, pwdata[status_reset_pkg::alu_a_lo +: 8]} + {1'b0, opnd_b}
      + {8'h00, pwdata[status_reset_pkg::alu_sub_bit]};
  assign sum_half = {1'b0, pwdata[status_reset_pkg::alu_a_lo +: 4]} + {1'b0, opnd_b[3:0]}
      + {4'h0, pwdata[status_reset_pkg::alu_sub_bit]};
  assign alu_res = pwdata[status_reset_pkg::alu_logic_bit] ?
      (pwdata[status_reset_pkg::alu_a_lo +: 8] & pwdata[status_reset_pkg::alu_b_lo +: 8]) :
      sum_full[7:0];

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.osc_prev = primary_oscillator_input;
    // ---------------------------------------------------------------
    // Reset sequencer
    // ---------------------------------------------------------------
    case (st_r.seq)
      status_reset_pkg::seq_por: begin
        // Counters restart from zero on every pass through supply reset
        st_nxt.power_up_delay_timer_cnt = '0;
        st_nxt.settle_cnt = '0;
        if (supply_good) begin
          if (st_r.power_up_delay_timer_en) begin
            st_nxt.seq = status_reset_pkg::seq_power_up_delay_timer;
          end else if (is_crystal(st_r.osc_mode)) begin
            st_nxt.seq = status_reset_pkg::seq_ost;
          end else begin
            st_nxt.seq = status_reset_pkg::seq_run;
          end
        end
      end
      status_reset_pkg::seq_power_up_delay_timer: begin
        if (rc_osc_tick) begin
          st_nxt.power_up_delay_timer_cnt = st_r.power_up_delay_timer_cnt + 1'b1;
        end
        // The count may step once past the limit in the same cycle the state moves on
        if (st_r.power_up_delay_timer_cnt == power_up_delay_timer_w'(power_up_delay_timer_ticks_p)) begin
          st_nxt.seq = is_crystal(st_r.osc_mode) ? status_reset_pkg::seq_ost :
              status_reset_pkg::seq_run;
        end
      end
      status_reset_pkg::seq_ost: begin
        if (primary_oscillator_input && !st_r.osc_prev) begin
          st_nxt.settle_cnt = st_r.settle_cnt + 1'b1;
        end
        if (st_r.settle_cnt == settle_w'(settle_ticks_p)) begin
          st_nxt.seq = status_reset_pkg::seq_run;
          // A wake from sleep ends here too
          st_nxt.sleeping = 1'b0;
        end
      end
      status_reset_pkg::seq_run: begin
        // Counters idle at zero so a later wake starts a full settle
        st_nxt.power_up_delay_timer_cnt = '0;
        st_nxt.settle_cnt = '0;
      end
      default: st_nxt.seq = status_reset_pkg::seq_por;
    endcase
    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // Dropped, not held, while the time-outs run
    if (wr_en && st_r.seq == status_reset_pkg::seq_run) begin
      if (is_status(paddr)) begin
        st_nxt.status = (pwdata[7:0] & ~status_reset_pkg::flag_mask & ~reserved_mask)
            | (st_r.status & status_reset_pkg::flag_mask);
      end else if (is_ctrl(paddr)) begin
        st_nxt.power_up_delay_timer_en = pwdata[status_reset_pkg::ctrl_power_up_delay_timer_en_bit];
        st_nxt.osc_mode = status_reset_pkg::osc_mode_e'(pwdata[status_reset_pkg::ctrl_osc_lo_bit +: 2]);
      end else if (paddr == status_reset_pkg::alu_addr) begin
        st_nxt.status[status_reset_pkg::zero_bit] = (alu_res == 8'h00);
        // Logic operations leave both carries as they were
        if (!pwdata[status_reset_pkg::alu_logic_bit]) begin
          st_nxt.status[status_reset_pkg::carry_bit] = sum_full[8];
          st_nxt.status[status_reset_pkg::half_byte_overflow_bit] = sum_half[4];
        end
        // arithmetic bits keep computed values
        // Only the bank select bit takes the result; the flags above win,
        // and the reset-cause and reserved bits are never written
        if (pwdata[status_reset_pkg::alu_dest_bit]) begin
          st_nxt.status[status_reset_pkg::bank_select_low_bit] =
              alu_res[status_reset_pkg::bank_select_low_bit];
        end
      end else if (paddr == status_reset_pkg::event_addr) begin
        // Several event bits may share one write; later ones win
        if (pwdata[status_reset_pkg::ev_clear_bit]) begin
          // clear upper bits, set zero flag
          st_nxt.status = (st_r.status & ~status_reset_pkg::status_upper_mask);
          st_nxt.status[status_reset_pkg::zero_bit] = 1'b1;
        end
        if (pwdata[status_reset_pkg::ev_sleep_bit]) begin
          st_nxt.status[status_reset_pkg::sleep_entered_bit] = 1'b0;
          st_nxt.status[status_reset_pkg::watchdog_expiry_bit] = 1'b1;
          st_nxt.sleeping = 1'b1;
        end
        if (pwdata[status_reset_pkg::ev_wdt_bit]) begin
          // watchdog expiry
          // Taken after sleep, so a combined write leaves expiry low
          st_nxt.status[status_reset_pkg::watchdog_expiry_bit] = 1'b0;
        end
        if (pwdata[status_reset_pkg::ev_wake_bit] || pwdata[status_reset_pkg::ev_master_clear_pin_bit]) begin
          if (st_r.sleeping) begin
            // wake or master clear from sleep
            st_nxt.status[status_reset_pkg::watchdog_expiry_bit] = 1'b1;
            st_nxt.status[status_reset_pkg::sleep_entered_bit] = 1'b0;
            // settle on wake in crystal modes only
            if (pwdata[status_reset_pkg::ev_wake_bit] && is_crystal(st_r.osc_mode)) begin
              st_nxt.seq = status_reset_pkg::seq_ost;
            end else begin
              st_nxt.sleeping = 1'b0;
            end
          end
        end
      end
    end
    // ---------------------------------------------------------------
    // Supply loss
    // ---------------------------------------------------------------
    // Applied after the writes, so a supply drop wins over a write or event
    // in the same cycle and the reset-cause flags always read as a power-up
    // supply loss restarts the chain
    if (!supply_good) begin
      st_nxt.seq = status_reset_pkg::seq_por;
      st_nxt.status[status_reset_pkg::watchdog_expiry_bit] = 1'b1;
      st_nxt.status[status_reset_pkg::sleep_entered_bit] = 1'b1;
      st_nxt.status[status_reset_pkg::bank_select_low_bit] = 1'b0;
    end
    // ---------------------------------------------------------------
    // Derived outputs
    // ---------------------------------------------------------------
    // direct bank base
    st_nxt.bank_base = st_nxt.status[status_reset_pkg::bank_select_low_bit] ?
        status_reset_pkg::bank_base_high : status_reset_pkg::bank_base_low;
    // master clear gates only the output
    // A held pin keeps reset on after the time-outs; its release acts next edge
    st_nxt.rst_out = (st_nxt.seq != status_reset_pkg::seq_run) || !master_clear_pin_n;
    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    // Read data stands one cycle, zero otherwise
    st_nxt.rdata = '0;
    if (rd_en) begin
      if (is_status(paddr)) begin
        st_nxt.rdata[7:0] = st_r.status;
      end else if (is_ctrl(paddr)) begin
        st_nxt.rdata[status_reset_pkg::ctrl_power_up_delay_timer_en_bit] = st_r.power_up_delay_timer_en;
        st_nxt.rdata[status_reset_pkg::ctrl_osc_lo_bit +: 2] = st_r.osc_mode;
      end else if (paddr == status_reset_pkg::seq_addr) begin
        st_nxt.rdata[1:0] = st_r.seq;
        st_nxt.rdata[2] = st_r.sleeping;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Power-up values; all other state clears
      st_r <= '0;
      st_r.status <= status_reset_pkg::status_por_value;
      st_r.power_up_delay_timer_en <= 1'b1;
      st_r.seq <= status_reset_pkg::seq_por;
      st_r.rst_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; no wait state, pready stays high
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign chip_reset = st_r.rst_out;
  assign data_bank_base = st_r.bank_base;
endmodule
`default_nettype wire

// [bench/status_reset_props.sv]
// Purpose: Concurrent checks on the status and reset chain ports
// Assumes: One pclk domain, presetn asynchronous active low
// Notes: Bound onto the top module
`timescale 1ns/1ps
`default_nettype none
module status_reset_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_good,
  input wire logic rc_osc_tick,
  input wire logic primary_oscillator_input,
  input wire logic master_clear_pin_n,
  input wire logic chip_reset,
  input wire logic [7:0] data_bank_base
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_now;
  logic st_rd;
  // Read strobes
  assign rd_now = psel && penable && !pwrite;
  assign st_rd = rd_now && (paddr == status_reset_pkg::status_addr_lo ||
    paddr == status_reset_pkg::status_addr_hi);
  property p_supply; !supply_good |-> ##[1:2] chip_reset; endproperty
  a_supply: assert property (p_supply) else $error("Low supply left reset off");
  property p_master_clear_pin; !master_clear_pin_n |-> ##[1:2] chip_reset; endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("Pin low left reset off");
  property p_rel; $fell(chip_reset) |-> $past(supply_good) && $past(master_clear_pin_n); endproperty
  a_rel: assert property (p_rel) else $error("Reset released too early");
  property p_bank; data_bank_base == 8'h00 || data_bank_base == 8'h80; endproperty
  a_bank: assert property (p_bank) else $error("Bad bank base");
  property p_bfol; $past(st_rd) |-> data_bank_base == {prdata[5], 7'h00}; endproperty
  a_bfol: assert property (p_bfol) else $error("Bank base differs from status");
  property p_up; $past(st_rd) |-> prdata[31:6] == 26'h000_0000; endproperty
  a_up: assert property (p_up) else $error("Status upper bits set");
  // Read data stands one cycle
  property p_idle; !$past(rd_now) |-> prdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("Read data not idle");
  // Zero wait, no error
  property p_rdy; psel && penable |-> pready && !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("Slave response wrong");
  // Main scenarios
  c_rel: cover property ($fell(chip_reset));
  c_hi: cover property (psel && penable && pwrite && paddr == status_reset_pkg::status_addr_hi);
  c_pin: cover property (!master_clear_pin_n && supply_good ##1 chip_reset);
endmodule
bind status_and_reset_timeout status_reset_props status_reset_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .supply_good(supply_good), .rc_osc_tick(rc_osc_tick),
  .primary_oscillator_input(primary_oscillator_input),
  .master_clear_pin_n(master_clear_pin_n), .chip_reset(chip_reset),
  .data_bank_base(data_bank_base));
`default_nettype wire

// [bench/supply_master_clear_pin_model.sv]
// Purpose: Supply monitor, oscillators and master clear pin
// Assumes: Levels follow bench requests one cycle later
// Notes: RC tick every five cycles, crystal period four cycles
`timescale 1ns/1ps
`default_nettype none
module supply_master_clear_pin_model (
  input wire logic pclk,
  input wire logic supply_on,
  input wire logic master_clear_pin_hold,
  output logic supply_good,
  output logic rc_osc_tick,
  output logic primary_oscillator_input,
  output logic master_clear_pin_n
);
  logic [2:0] rc_cnt = 3'h0;
  logic [1:0] osc_cnt = 2'h0;
  logic sup_r = 1'b0;
  logic hold_r = 1'b0;
  // Tick and crystal outputs
  assign rc_osc_tick = (rc_cnt == 3'h4);
  assign primary_oscillator_input = osc_cnt[1];
  assign supply_good = sup_r;
  assign master_clear_pin_n = !hold_r;
  // Free-running oscillators and registered levels
  always @(posedge pclk) begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    osc_cnt <= osc_cnt + 2'h1;
    sup_r <= supply_on;
    hold_r <= master_clear_pin_hold;
  end
endmodule
`default_nettype wire

// [bench/test_status_and_reset_timeout.sv]
// Purpose: Self-checking bench for the status register and reset chain
// Assumes: Zero-wait APB, read data valid one cycle after the access edge
// Notes: Short delay and settle counts keep power cycles brief
`timescale 1ns/1ps
`default_nettype none
module test_status_and_reset_timeout;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic supply_on = 1'b0;
  logic master_clear_pin_hold = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, supply_good, rc_osc_tick, osc_in, master_clear_pin_n, chip_reset;
  logic [7:0] data_bank_base;
  logic [31:0] exp_q[$];
  logic [4:0] evs [5] = '{5'h02, 5'h04, 5'h08, 5'h02, 5'h10};
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // Clock
  always #50 pclk = ~pclk;
  status_and_reset_timeout #(.power_up_delay_timer_ticks_p(8), .settle_ticks_p(4)) status_and_reset_timeout_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_good(supply_good), .rc_osc_tick(rc_osc_tick), .primary_oscillator_input(osc_in),
    .master_clear_pin_n(master_clear_pin_n), .chip_reset(chip_reset),
    .data_bank_base(data_bank_base));
  supply_master_clear_pin_model supply_master_clear_pin_model_inst (
    .pclk(pclk), .supply_on(supply_on), .master_clear_pin_hold(master_clear_pin_hold), .supply_good(supply_good),
    .rc_osc_tick(rc_osc_tick), .primary_oscillator_input(osc_in),
    .master_clear_pin_n(master_clear_pin_n));
  // Verdict and end of run
  task complete_run;
    $display("Mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Compare a read word
  task cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  // Compare a single flag
  task cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // APB transfer, a read notes its expected word
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rs(input logic [7:0] e);
    apb(1'b0, status_reset_pkg::status_addr_lo, {24'h00_0000, e});
  endtask
  // Cycles until the chip leaves reset
  task settle(output int n);
    n = 0;
    while (chip_reset !== 1'b0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Supply drop and rise with a given configuration
  task pcycle(input logic [2:0] ctl, input int lo, input int hi);
    int n;
    apb(1'b1, status_reset_pkg::ctrl_addr, {29'h0000_0000, ctl});
    supply_on <= 1'b0;
    repeat (4) @(posedge pclk);
    cmp_bit(chip_reset, 1'b1);
    supply_on <= 1'b1;
    settle(n);
    cmp_bit(n >= lo && n <= hi, 1'b1);
  endtask
  // Status after an operation
  function automatic logic [7:0] alu_st(input logic [7:0] s, input logic [7:0] a,
    input logic [7:0] b, input logic [2:0] op);
    logic [8:0] r;
    logic [4:0] h;
    if (op[2]) r = {1'b0, a & b};
    else if (op[0]) r = {1'b0, a} + {1'b0, ~b} + 9'h001;
    else r = {1'b0, a} + {1'b0, b};
    if (op[0]) h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    else h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    if (op[1]) s = (s & 8'h1F) | (r[7:0] & 8'h20);
    s[2] = (r[7:0] == 8'h00);
    if (!op[2]) s[1:0] = {h[4], r[8]};
    return s;
  endfunction
  // Result watcher and timeout
  always @(posedge pclk) begin
    if (rd_seen) cmp_rd(prdata, exp_q.pop_front());
    rd_seen <= psel && penable && !pwrite;
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    int n;
    logic [7:0] st, w, a, b;
    logic [2:0] op;
    void'($urandom(52));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    pcycle(3'b001, 46, 87);
    apb(1'b0, status_reset_pkg::seq_addr, 32'h0000_0003);
    rs(8'h18);
    apb(1'b0, status_reset_pkg::status_addr_hi, 32'h0000_0018);
    apb(1'b0, 12'h7F0, 32'h0000_0000);
    st = 8'h18;
    for (int i = 0; i < 4; i++) begin
      w = 8'($urandom);
      apb(1'b1, i[0] ? status_reset_pkg::status_addr_hi : status_reset_pkg::status_addr_lo,
        {24'h00_0000, w});
      st = (w & 8'h27) | (st & 8'h18);
      rs(st);
      cmp_bit(data_bank_base === {st[5], 7'h00}, 1'b1);
    end
    apb(1'b1, status_reset_pkg::event_addr, 32'h0000_0001);
    st = (st & 8'h1F) | 8'h04;
    rs(st);
    for (int i = 0; i < 6; i++) begin
      a = 8'($urandom);
      b = (i == 0) ? a : 8'($urandom);
      op = (i == 0) ? 3'b011 : 3'($urandom);
      if (op[2]) op[0] = 1'b0;
      apb(1'b1, status_reset_pkg::alu_addr, {13'h0000, op, b, a});
      st = alu_st(st, a, b, op);
      rs(st);
    end
    apb(1'b1, status_reset_pkg::status_addr_lo, 32'h0000_0000);
    st = st & 8'h18;
    rs(st);
    foreach (evs[i]) begin
      apb(1'b1, status_reset_pkg::event_addr, {27'h000_0000, evs[i]});
      st = (evs[i] == 5'h04) ? (st & 8'hEF) : ((st & 8'hF7) | 8'h10);
      repeat (3) @(posedge pclk);
      settle(n);
      cmp_bit(n > 0, evs[i] == 5'h08);
      rs(st);
    end
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 2; e++) begin
        pcycle({m[1:0], e[0]}, e * 34 + (m < 3 ? 12 : 0), e * 52 + (m < 3 ? 30 : 0) + 5);
      end
    end
    rs(8'h18);
    master_clear_pin_hold <= 1'b1;
    supply_on <= 1'b0;
    repeat (4) @(posedge pclk);
    supply_on <= 1'b1;
    repeat (120) @(posedge pclk);
    cmp_bit(chip_reset, 1'b1);
    master_clear_pin_hold <= 1'b0;
    repeat (4) @(posedge pclk);
    cmp_bit(chip_reset, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
